// ---- bfr_pkg.sv ----
/*
  bfr_pkg: constants and carrier types for the bus fault reporting block.
  assumes one clock domain and a 32-bit apb register bus.
*/
package bfr_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_MOD_FAULT = 8'h00; // module fault flags, w1c
  localparam logic [7:0] OFF_BUS_FAULT = 8'h04; // bus fault flags, w1c
  localparam logic [7:0] OFF_CAP_ADDR = 8'h08;  // captured bus address
  localparam logic [7:0] OFF_CAP_CMD = 8'h0C;   // captured bus command
  localparam logic [7:0] OFF_CTRL = 8'h10;      // control
  // ==========================================================
  // module fault register bits
  localparam int MF_CSTAT = 0; // cache state parity
  localparam int MF_CTAG = 1;  // cache tag parity
  localparam int MF_PMAP = 2;  // primary map parity
  localparam int MF_BMAP = 3;  // secondary map parity
  localparam int MF_DROP = 4;  // grant unused
  localparam int MF_CLASH = 5; // arbitration clash
  localparam int MF_W = 6;
  // ==========================================================
  // bus fault register bits
  localparam int BF_NODE_SPECIFIC_FAULT_SUMMARY = 0;  // node specific summary
  localparam int BF_CECHO = 1; // command echo mismatch
  localparam int BF_DECHO = 2; // data echo mismatch
  localparam int BF_NXA = 3;   // nonexistent address
  localparam int BF_CPE = 4;   // command parity
  localparam int BF_CAPV = 5;  // capture holds data
  localparam int BF_IRQ4 = 8;  // pending level on interrupt pin 4
  localparam int BF_IRQ5 = 9;  // pending level on interrupt pin 5
  localparam int BF_W = 10;
  // ==========================================================
  // reset values and ack codes
  localparam logic [MF_W-1:0] MF_RST = 6'h00;
  localparam logic [BF_W-1:0] BF_RST = 10'h000;
  localparam logic CTRL_RST = 1'h1; // snoop responses enabled
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_OK = 2'h1;
  localparam logic [1:0] ACK_HARD = 2'h3; // hard fault ack code
  // ==========================================================
  // detector events from the cache and map logic, one-cycle pulses
  typedef struct packed {
    logic cstat_pe;    // cache state parity error
    logic cstat_snoop; // cstat_pe seen during a snoop evaluation
    logic ctag_pe;     // cache tag parity error
    logic pmap_pe;     // primary map parity error
    logic bmap_pe;     // secondary map parity error
    logic cmd_pe;      // bus command parity error
    logic cmd_own_cpu; // that command served a cpu request
  } bfr_evt_t;
  // snoop lookup result
  typedef struct packed {
    logic valid;     // lookup done this cycle
    logic bmap_hit;  // secondary map hit
    logic bmap_dirty; // secondary map says dirty
    logic pmap_hit;  // primary map hit
  } bfr_snoop_t;
endpackage

// ---- bfr_fault_unit.sv ----
/*
  bfr_fault_unit: classifies bus and cache faults, answers a waiting cpu
  with a hard fault ack or raises interrupt levels, drives the bus error
  line, latches fault state and exposes it over apb.
  assumes all inputs synchronous to ref_clk_i and a one-transfer apb master.
*/
// Our own choices: the APB register port and the register offsets.
// Operation
// - waiting cpu gets hard ack for five faults
// - all other faults go to interrupt pins
// - async faults raise the module fault signal
// - state parity: cpu ack, snoop interrupt
// - state parity sets flag, summary, capture
// - state parity: bus error, shared/dirty low
// - tag parity gives hard ack if cpu waits, else pin 4
// - tag parity sets flag, summary, capture
// - primary map parity raises pin 5, capture
// - primary map fault: dirty from secondary, shared
// - secondary map parity: pin 5, error line
// - unused grant: hard ack or pin 4
// - unused grant sets flag, summary, capture
// - ask lines misused: pin 5, no capture
// - echo mismatch raises pin 5, sets flag
// - every reported fault asserts bus error
// - bus error resynchronizes arbitration
// - missing confirm flags nonexistent address
`timescale 1ns/1ps
module bfr_fault_unit #(
  parameter int AW = 32, // bus address width
  parameter int CW = 4,  // bus command width
  parameter int DW = 32  // echo compare width
) (
  input wire logic ref_clk_i,              // 200 MHz clock
  input wire logic resetn_i,               // async reset, active low
  input wire logic psel_i,                 // apb select
  input wire logic penable_i,              // apb enable
  input wire logic pwrite_i,               // apb direction
  input wire logic [7:0] paddr_i,          // apb byte address
  input wire logic [31:0] pwdata_i,        // apb write data
  output logic [31:0] prdata_o,            // apb read data
  output logic pready_o,                   // apb ready
  output logic pslverr_o,                  // apb error, unmapped
  input wire logic cpu_wait_i,             // cpu waits for an ack
  input wire logic cpu_done_i,             // cpu request completes
  input wire bfr_pkg::bfr_evt_t evt_i,     // detector pulses
  input wire bfr_pkg::bfr_snoop_t snoop_i, // snoop lookup result
  input wire logic arb_grant_i,            // grant given this cycle
  input wire logic grant_own_cpu_i,        // grant serves our cpu
  input wire logic ca_i,                   // command address strobe
  input wire logic ca_own_cpu_i,           // our strobe for a cpu request
  input wire logic confirm_i,              // confirm signal
  input wire logic ask_any_i,              // any ask line driven
  input wire logic ask_window_i,           // asking is legal now
  input wire logic tx_valid_i,             // we drive a word now
  input wire logic tx_is_cmd_i,            // driven word is a command
  input wire logic [DW-1:0] tx_word_i,     // word driven
  input wire logic [DW-1:0] rx_word_i,     // word received back
  input wire logic [AW-1:0] bus_addr_i,    // current bus address
  input wire logic [CW-1:0] bus_cmd_i,     // current bus command
  input wire logic bus_err_in_i,           // error line seen from bus
  output logic [1:0] cycle_ack_lines_o,    // ack code to cpu
  output logic irq4_o,                     // interrupt pin 4 level
  output logic irq5_o,                     // interrupt pin 5 level
  output logic module_fault_signal_o,      // any async fault pending
  output logic bus_err_o,                  // bus error line drive
  output logic shared_o,                   // snoop shared response
  output logic dirty_o,                    // snoop dirty response
  output logic arb_resync_o                // arbitration resync pulse
);

  // ==========================================================
  // state
  logic [bfr_pkg::MF_W-1:0] module_fault_register; // sticky cache/arb flags
  logic [bfr_pkg::MF_W-1:0] next_module_fault_register;
  logic [bfr_pkg::BF_W-1:0] bus_fault_register; // sticky bus flags
  logic [bfr_pkg::BF_W-1:0] next_bus_fault_register;
  logic [AW-1:0] cap_addr; // fault command capture, address
  logic [AW-1:0] next_cap_addr;
  logic [CW-1:0] cap_cmd; // fault command capture, command
  logic [CW-1:0] next_cap_cmd;
  logic ctrl_snoop_en; // software: take part in snoop responses
  logic next_ctrl_snoop_en;
  logic grant_q, next_grant_q; // grant seen last cycle
  logic grant_cpu_q, next_grant_cpu_q;
  logic ca_q, next_ca_q; // strobe seen last cycle
  logic ca_cpu_q, next_ca_cpu_q;
  logic [1:0] next_ack;
  logic next_irq4, next_irq5, next_bus_err, next_shared, next_dirty, next_resync;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  // ==========================================================
  // fault classification, combinational
  logic drop, nxa, clash, cecho, decho; // derived fault pulses
  logic sync_hard_fault_ack_bit; // fault that stops the pending cpu request
  logic async4, async5; // faults reported on an interrupt pin
  logic any_fault, do_capture;
  logic wr_hit; // apb write takes effect this edge
  logic [31:0] wclr; // write-one-to-clear mask

  // echo check used for both command and data words
  function automatic logic echo_bad(input logic [DW-1:0] a, input logic [DW-1:0] b);
    echo_bad = (a != b);
  endfunction

  // derive pulses and split them into sync and async classes
  always_comb begin
    // granted node never strobed the command cycle
    drop = grant_q & ~ca_i;
    nxa = ca_q & ~confirm_i;
    // ask lines outside their legal window
    clash = ask_any_i & ~ask_window_i;
    // compare driven word with received word
    cecho = tx_valid_i & tx_is_cmd_i & echo_bad(tx_word_i, rx_word_i);
    decho = tx_valid_i & ~tx_is_cmd_i & echo_bad(tx_word_i, rx_word_i);
    // only five faults stop a waiting cpu request
    // state parity is synchronous only for cpu lookups
    sync_hard_fault_ack_bit = cpu_wait_i & (evt_i.ctag_pe
                | (evt_i.cstat_pe & ~evt_i.cstat_snoop)
                | (drop & grant_cpu_q)
                | (evt_i.cmd_pe & evt_i.cmd_own_cpu)
                | (nxa & ca_cpu_q));
    // everything else goes to an interrupt pin
    async4 = ~sync_hard_fault_ack_bit & (drop | nxa | evt_i.cmd_pe | evt_i.cstat_pe | evt_i.ctag_pe);
    // primary map, secondary map on pin 5
    async5 = evt_i.pmap_pe | evt_i.bmap_pe | clash | cecho | decho;
    any_fault = sync_hard_fault_ack_bit | async4 | async5;
    // capture for state parity, tag, map parity, drop, nxa, command parity
    // clash and echo faults carry no capture
    do_capture = (evt_i.cstat_pe | evt_i.ctag_pe | evt_i.pmap_pe | evt_i.bmap_pe
                  | drop | nxa | evt_i.cmd_pe) & ~bus_fault_register[bfr_pkg::BF_CAPV];
  end

  // ==========================================================
  // apb decode and register next values
  // reads answer one cycle into the access phase; writes land on the
  // edge that sees pready high, so a held request never writes twice
  always_comb begin
    wr_hit = psel_i & penable_i & pready_o & pwrite_i;
    wclr = wr_hit ? pwdata_i : 32'h0000_0000;
    next_pready = psel_i & penable_i & ~pready_o;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_ctrl_snoop_en = ctrl_snoop_en;
    // read mux, unused upper bits read zero
    case (paddr_i)
      bfr_pkg::OFF_MOD_FAULT: next_prdata[bfr_pkg::MF_W-1:0] = module_fault_register;
      bfr_pkg::OFF_BUS_FAULT: next_prdata[bfr_pkg::BF_W-1:0] = bus_fault_register;
      bfr_pkg::OFF_CAP_ADDR: next_prdata[AW-1:0] = cap_addr;
      bfr_pkg::OFF_CAP_CMD: next_prdata[CW-1:0] = cap_cmd;
      bfr_pkg::OFF_CTRL: next_prdata[0] = ctrl_snoop_en;
      default: next_pslverr = psel_i & penable_i & ~pready_o; // unmapped
    endcase
    if (!next_pready) begin
      next_prdata = 32'h0000_0000;
    end
    if (wr_hit && paddr_i == bfr_pkg::OFF_CTRL) begin
      next_ctrl_snoop_en = pwdata_i[0];
    end
    if (!(paddr_i == bfr_pkg::OFF_MOD_FAULT)) begin
      wclr[bfr_pkg::MF_W-1:0] = (paddr_i == bfr_pkg::OFF_BUS_FAULT) ? wclr[bfr_pkg::MF_W-1:0]
                                : {bfr_pkg::MF_W{1'b0}};
    end
  end

  // ==========================================================
  // sticky flags, capture and pin levels
  // a set arriving with its clear wins, so no fault is lost
  always_comb begin
    // flags stay until software writes a one
    next_module_fault_register = module_fault_register
      & ~((paddr_i == bfr_pkg::OFF_MOD_FAULT) ? wclr[bfr_pkg::MF_W-1:0] : {bfr_pkg::MF_W{1'b0}});
    next_bus_fault_register = bus_fault_register
      & ~((paddr_i == bfr_pkg::OFF_BUS_FAULT) ? wclr[bfr_pkg::BF_W-1:0] : {bfr_pkg::BF_W{1'b0}});
    if (evt_i.cstat_pe) next_module_fault_register[bfr_pkg::MF_CSTAT] = 1'b1;
    if (evt_i.ctag_pe) next_module_fault_register[bfr_pkg::MF_CTAG] = 1'b1;
    if (evt_i.pmap_pe) next_module_fault_register[bfr_pkg::MF_PMAP] = 1'b1;
    if (evt_i.bmap_pe) next_module_fault_register[bfr_pkg::MF_BMAP] = 1'b1;
    if (drop) next_module_fault_register[bfr_pkg::MF_DROP] = 1'b1;
    if (clash) next_module_fault_register[bfr_pkg::MF_CLASH] = 1'b1;
    // summary bit follows any module-level fault
    if (evt_i.cstat_pe | evt_i.ctag_pe | evt_i.pmap_pe | evt_i.bmap_pe | drop | clash) begin
      next_bus_fault_register[bfr_pkg::BF_NODE_SPECIFIC_FAULT_SUMMARY] = 1'b1;
    end
    if (cecho) next_bus_fault_register[bfr_pkg::BF_CECHO] = 1'b1;
    if (decho) next_bus_fault_register[bfr_pkg::BF_DECHO] = 1'b1;
    if (nxa) next_bus_fault_register[bfr_pkg::BF_NXA] = 1'b1;
    if (evt_i.cmd_pe) next_bus_fault_register[bfr_pkg::BF_CPE] = 1'b1;
    if (async4) next_bus_fault_register[bfr_pkg::BF_IRQ4] = 1'b1;
    if (async5) next_bus_fault_register[bfr_pkg::BF_IRQ5] = 1'b1;
    // only the first fault is captured, later ones keep it intact
    next_cap_addr = cap_addr;
    next_cap_cmd = cap_cmd;
    if (do_capture) begin
      next_bus_fault_register[bfr_pkg::BF_CAPV] = 1'b1;
      next_cap_addr = bus_addr_i;
      next_cap_cmd = bus_cmd_i;
    end
    next_irq4 = next_bus_fault_register[bfr_pkg::BF_IRQ4];
    next_irq5 = next_bus_fault_register[bfr_pkg::BF_IRQ5];
  end

  // ==========================================================
  // cpu ack, bus error, snoop answer, resync
  always_comb begin
    // hard code replaces the normal ack
    // the cpu latches its hard bit from this code
    if (sync_hard_fault_ack_bit) begin
      next_ack = bfr_pkg::ACK_HARD;
    end else if (cpu_done_i) begin
      next_ack = bfr_pkg::ACK_OK;
    end else begin
      next_ack = bfr_pkg::ACK_NONE;
    end
    // every reported fault drives the error line
    next_bus_err = any_fault;
    // resync on our own or any other error assertion
    next_resync = bus_err_o | bus_err_in_i;
    next_shared = 1'b0;
    next_dirty = 1'b0;
    if (snoop_i.valid && ctrl_snoop_en) begin
      if (evt_i.bmap_pe | evt_i.cstat_pe) begin
        // state parity: leave shared and dirty low
        next_shared = 1'b0;
        next_dirty = 1'b0;
      end else if (evt_i.pmap_pe) begin
        // assume primary hit, dirty from secondary alone
        next_shared = 1'b1;
        next_dirty = snoop_i.bmap_dirty;
      end else begin
        next_shared = snoop_i.bmap_hit & snoop_i.pmap_hit;
        next_dirty = snoop_i.bmap_hit & snoop_i.bmap_dirty;
      end
    end
    next_grant_q = arb_grant_i;
    next_grant_cpu_q = arb_grant_i & grant_own_cpu_i;
    next_ca_q = ca_i;
    next_ca_cpu_q = ca_i & ca_own_cpu_i;
  end

  // ==========================================================
  // registers, reset to constants only
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      module_fault_register <= bfr_pkg::MF_RST;
      bus_fault_register <= bfr_pkg::BF_RST;
      cap_addr <= '0;
      cap_cmd <= '0;
      ctrl_snoop_en <= bfr_pkg::CTRL_RST;
      grant_q <= 1'b0;
      grant_cpu_q <= 1'b0;
      ca_q <= 1'b0;
      ca_cpu_q <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      cycle_ack_lines_o <= bfr_pkg::ACK_NONE;
      irq4_o <= 1'b0;
      irq5_o <= 1'b0;
      module_fault_signal_o <= 1'b0;
      bus_err_o <= 1'b0;
      shared_o <= 1'b0;
      dirty_o <= 1'b0;
      arb_resync_o <= 1'b0;
    end else begin
      module_fault_register <= next_module_fault_register;
      bus_fault_register <= next_bus_fault_register;
      cap_addr <= next_cap_addr;
      cap_cmd <= next_cap_cmd;
      ctrl_snoop_en <= next_ctrl_snoop_en;
      grant_q <= next_grant_q;
      grant_cpu_q <= next_grant_cpu_q;
      ca_q <= next_ca_q;
      ca_cpu_q <= next_ca_cpu_q;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      cycle_ack_lines_o <= next_ack;
      irq4_o <= next_irq4;
      irq5_o <= next_irq5;
      // module fault signal mirrors any pending pin level
      module_fault_signal_o <= next_irq4 | next_irq5;
      bus_err_o <= next_bus_err;
      shared_o <= next_shared;
      dirty_o <= next_dirty;
      arb_resync_o <= next_resync;
    end
  end

endmodule // bfr_fault_unit

// ---- bfr_props.sv ----
/* bfr_props: port checks on the fault unit, bound to every instance.
   assumes one clock and an active-low async reset on the unit. */
`timescale 1ns/1ps
module bfr_props (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic cpu_wait_i, // cpu waits
  input wire bfr_pkg::bfr_evt_t evt_i, // detector pulses
  input wire bfr_pkg::bfr_snoop_t snoop_i, // snoop lookup
  input wire logic arb_grant_i, // grant
  input wire logic grant_own_cpu_i, // grant for cpu
  input wire logic ca_i, // strobe
  input wire logic ask_any_i, // ask lines driven
  input wire logic ask_window_i, // asking legal
  input wire logic [1:0] cycle_ack_lines_o, // ack code
  input wire logic irq4_o, // pin 4
  input wire logic irq5_o, // pin 5
  input wire logic module_fault_signal_o, // fault level
  input wire logic bus_err_o, // error line
  input wire logic shared_o, // shared
  input wire logic dirty_o, // dirty
  input wire logic arb_resync_o // resync
);
  // ==========================================================
  // one domain; reset silences every check
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // unused grant: own grant, then no strobe while cpu still waits
  sequence s_grant; arb_grant_i && grant_own_cpu_i && cpu_wait_i; endsequence
  sequence s_no_ca; !ca_i && cpu_wait_i; endsequence
  a_tag_hard: assert property (
    evt_i.ctag_pe && cpu_wait_i |=> cycle_ack_lines_o == bfr_pkg::ACK_HARD)
    else $error("tag parity without hard ack");
  a_hard_waits: assert property (
    cycle_ack_lines_o == bfr_pkg::ACK_HARD |-> $past(cpu_wait_i))
    else $error("hard ack while cpu idle");
  a_snoop_state: assert property (
    evt_i.cstat_pe && evt_i.cstat_snoop |=> irq4_o && cycle_ack_lines_o != bfr_pkg::ACK_HARD)
    else $error("snoop state parity not on pin 4");
  a_pin5_cause: assert property (
    evt_i.pmap_pe || evt_i.bmap_pe || ask_any_i && !ask_window_i |=> irq5_o)
    else $error("map or clash fault not on pin 5");
  a_fault_level: assert property (
    $rose(irq4_o) || $rose(irq5_o) |-> ##[0:1] module_fault_signal_o)
    else $error("fault signal missing");
  a_err_resync: assert property (
    bus_err_o |=> arb_resync_o)
    else $error("no resync after error line");
  a_drop_hard: assert property (
    s_grant ##1 s_no_ca |=> cycle_ack_lines_o == bfr_pkg::ACK_HARD)
    else $error("own unused grant without hard ack");
  a_snoop_quiet: assert property (
    snoop_i.valid && (evt_i.bmap_pe || evt_i.cstat_pe) |=> !shared_o && !dirty_o)
    else $error("snoop answered after parity fault");
endmodule // bfr_props
bind bfr_fault_unit bfr_props u_bfr_props (.*);

// ---- bfr_far_model.sv ----
/* bfr_far_model: cpu bus unit status and the far nodes' error line.
   assumes one clock; the error line is a wired-or of all nodes. */
`timescale 1ns/1ps
module bfr_far_model (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic [1:0] ack_i, // cycle ack code
  input wire logic irq4_i, // interrupt pin 4
  input wire logic cpu_read_i, // pending request is a read
  input wire logic bus_err_i, // our drive of the error line
  input wire logic inject_i, // a far node raises the line
  output logic bus_err_line_o, // wired error line
  output logic hard_bit_o, // cpu status hard bit
  output logic [4:0] trap_level_o, // priority of trap taken
  output logic resync_o // far arbitration resync
);
  logic next_hard; // next hard bit
  logic [4:0] next_level; // next trap priority
  // any node may pull the shared line
  assign bus_err_line_o = bus_err_i | inject_i;
  // status bit, check on read, interrupt otherwise
  always_comb begin
    next_hard = (ack_i == bfr_pkg::ACK_HARD) | (hard_bit_o & (ack_i != bfr_pkg::ACK_OK));
    next_level = irq4_i ? 5'h1D : 5'h00;
    if (ack_i == bfr_pkg::ACK_HARD) begin
      next_level = cpu_read_i ? 5'h1F : 5'h1D;
    end
  end
  // far nodes resync on the line
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {hard_bit_o, trap_level_o, resync_o} <= 7'h00;
    end else begin
      {hard_bit_o, trap_level_o, resync_o} <= {next_hard, next_level, bus_err_line_o};
    end
  end
endmodule // bfr_far_model

// ---- bus_error_reporting_test.sv ----
/* bus_error_reporting_test: random fault events with corner cases.
   assumes bfr_far_model on the far side and bfr_props bound in. */
`timescale 1ns/1ps
module bus_error_reporting_test;
  // ==========================================================
  // ports, far side and bench state
  logic ref_clk_i = 1'b0, resetn_i = 1'b0; // clock, reset
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0; // apb controls
  logic [7:0] paddr_i = 8'h00; // apb address
  logic [31:0] pwdata_i = 32'h0, prdata_o, d, lf = 32'h1C; // apb data, random state
  logic pready_o, pslverr_o, e, w, s, capv; // apb answer, expectations
  logic cpu_wait_i = 1'b0, cpu_done_i = 1'b0; // cpu side
  bfr_pkg::bfr_evt_t evt_i = '0; // detector pulses
  bfr_pkg::bfr_snoop_t snoop_i = '0; // snoop lookup
  logic arb_grant_i = 1'b0, grant_own_cpu_i = 1'b0, ca_i = 1'b0, ca_own_cpu_i = 1'b0; // bus
  logic confirm_i = 1'b1, ask_any_i = 1'b0, ask_window_i = 1'b1; // confirm, ask lines
  logic tx_valid_i = 1'b0, tx_is_cmd_i = 1'b0; // echo compare
  logic [31:0] tx_word_i = 32'h0, rx_word_i = 32'h0, bus_addr_i = 32'h0; // words
  logic [3:0] bus_cmd_i = 4'h0; // bus command
  logic bus_err_in_i, inject = 1'b0, hard_bit, far_resync; // far side
  logic [4:0] trap_level; // far trap priority
  logic [1:0] cycle_ack_lines_o, iq; // ack, expected {pin5, pin4}
  logic irq4_o, irq5_o, module_fault_signal_o, bus_err_o, shared_o, dirty_o, arb_resync_o;
  int fails = 0, tests_run = 0, k;
  bfr_fault_unit u_bfr_fault_unit (.*);
  bfr_far_model u_bfr_far_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .ack_i(cycle_ack_lines_o), .irq4_i(irq4_o), .cpu_read_i(lf[2]), .bus_err_i(bus_err_o),
    .inject_i(inject), .bus_err_line_o(bus_err_in_i), .hard_bit_o(hard_bit),
    .trap_level_o(trap_level), .resync_o(far_resync));
  always #2.5 ref_clk_i = ~ref_clk_i;
  // lfsr step and expected interrupt pins per fault kind
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [1:0] irq_exp(input int kk, input logic sy);
    if (sy) return 2'b00;
    return (kk inside {3, 4, 7, 8, 9}) ? 2'b10 : 2'b01;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, wr, a, wd};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    for (int n = 0; n < 9 && pready_o !== 1'b1; n++) @(posedge ref_clk_i);
    fails += (pready_o !== 1'b1);
    {d, e} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
    // idle edge, so the next call never re-drives psel in this step
    @(posedge ref_clk_i);
  endtask
  task automatic conclude;
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    conclude();
  end
  // ==========================================================
  // reset values, unmapped place, foreign error, then random faults
  initial begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    apb(1'b0, bfr_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", d, 32'h1);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    chk("unmapped write", {d[30:0], e}, 32'h1);
    inject <= 1'b1;
    @(posedge ref_clk_i);
    inject <= 1'b0;
    @(posedge ref_clk_i);
    chk("foreign resync", {arb_resync_o, far_resync}, 2'b11);
    // snoop answers switched off by software
    apb(1'b1, bfr_pkg::OFF_CTRL, 32'h0);
    snoop_i <= 4'hF;
    @(posedge ref_clk_i);
    snoop_i <= 4'h0;
    @(posedge ref_clk_i);
    chk("snoop off", {shared_o, dirty_o}, 2'b00);
    apb(1'b1, bfr_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 44; i++) begin
      k = i % 11;
      lf = nx(lf);
      w = lf[0] | (k == 2);
      s = w & ((k == 0) | (k == 2) | (lf[1] & ((k == 5) | (k == 6) | (k == 10))));
      iq = irq_exp(k, s);
      capv = (k < 7) | (k == 10);
      {cpu_wait_i, cpu_done_i} <= 2'b11;
      @(posedge ref_clk_i);
      cpu_done_i <= 1'b0;
      @(posedge ref_clk_i);
      chk("ack ok", cycle_ack_lines_o, bfr_pkg::ACK_OK);
      // evt order: cstat, snoop, tag, pmap, bmap, cmd parity, own
      evt_i <= {k < 2, k == 1, k == 2, k == 3, k == 4, k == 5, lf[1]};
      snoop_i <= {(k == 1) | (k == 3) | (k == 4), 1'b1, lf[4], lf[5]};
      {cpu_wait_i, arb_grant_i, grant_own_cpu_i, ca_i, ca_own_cpu_i} <= {w, k == 6, lf[1], k == 10, lf[1]};
      {ask_any_i, ask_window_i, tx_valid_i, tx_is_cmd_i} <= {k == 7, k != 7, k inside {8, 9}, k == 8};
      {tx_word_i, rx_word_i} <= {lf, lf ^ {31'h0, k inside {8, 9}}};
      {bus_addr_i, bus_cmd_i} <= {~lf, lf[11:8]};
      @(posedge ref_clk_i);
      chk("status after ok", hard_bit, 1'b0);
      {evt_i, snoop_i, arb_grant_i, ca_i, ask_any_i, ask_window_i, tx_valid_i} <= 16'h2;
      confirm_i <= k != 10;
      if (k == 6 || k == 10) @(posedge ref_clk_i);
      confirm_i <= 1'b1;
      @(posedge ref_clk_i);
      chk("ack, error line", {cycle_ack_lines_o, bus_err_o}, {s ? 2'h3 : 2'h0, 1'b1});
      if (k inside {1, 3, 4}) chk("snoop", {shared_o, dirty_o}, {k == 3, k == 3 & lf[4]});
      @(posedge ref_clk_i);
      chk("resync, hard bit, trap", {arb_resync_o, hard_bit, trap_level},
          {1'b1, s, s ? (lf[2] ? 5'h1F : 5'h1D) : (iq[0] ? 5'h1D : 5'h00)});
      apb(1'b0, bfr_pkg::OFF_MOD_FAULT, 32'h0);
      chk("mod flags", d, {26'h0, k == 7, k == 6, k == 4, k == 3, k == 2, k < 2});
      apb(1'b0, bfr_pkg::OFF_BUS_FAULT, 32'h0);
      chk("bus flags", d, {22'h0, iq, 2'b0, capv, k == 5, k == 10, k == 9, k == 8, k < 8 && k != 5});
      apb(1'b0, bfr_pkg::OFF_CAP_ADDR, 32'h0);
      if (capv) chk("capture addr", d, ~lf);
      apb(1'b0, bfr_pkg::OFF_CAP_CMD, 32'h0);
      if (capv) chk("capture cmd", d, {28'h0, lf[11:8]});
      chk("pins held", {irq5_o, irq4_o, module_fault_signal_o}, {iq, |iq});
      apb(1'b1, bfr_pkg::OFF_MOD_FAULT, 32'hFFFF_FFFF);
      apb(1'b1, bfr_pkg::OFF_BUS_FAULT, 32'hFFFF_FFFF);
      apb(1'b0, bfr_pkg::OFF_BUS_FAULT, 32'h0);
      chk("cleared", {d[30:0], irq5_o | irq4_o}, 32'h0);
    end
    conclude();
  end
endmodule // bus_error_reporting_test
